/* File: core/pmb_defs.svh */
// constants for the pmbus slave address and busy logic
`ifndef PMB_DEFS_SVH
`define PMB_DEFS_SVH

// core clock rate in kHz (10 MHz)
`define PMB_CLK_KHZ 10000

// addressing
`define PMB_BASE_RST 7'h5C
`define PMB_GLOBAL_ADDR 7'h5B
`define PMB_ARA_ADDR 7'h0C
`define PMB_STRAP_MULT 3
`define PMB_OFFSET_MAX 8

// common-status command code and its ready bit
`define PMB_STATUS_CMD_RST 8'hF0
`define PMB_READY_BIT 6

// busy times as printed, in ms or us
`define PMB_T_STORE_MS 100
`define PMB_T_RESTORE_MS 30
`define PMB_T_LOG_CLEAR_MS 175
`define PMB_T_LOG_STORE_MS 20
`define PMB_T_LOG_RESTORE_MS 2
`define PMB_T_NVM_MS 100
`define PMB_T_CFG_US 50
`define PMB_T_CLR_US 500

// cycle counts derived from the times
`define PMB_CYC_MS(t) ((t) * `PMB_CLK_KHZ)
`define PMB_CYC_US(t) (((t) * `PMB_CLK_KHZ) / 1000)

// busy counter width
`define PMB_CNT_W 24

`endif

/* File: core/pmb_pkg.sv */
// types shared by the pmbus slave address and busy logic
package pmb_pkg;

	// internal operations that the command core reports
	typedef enum logic [3:0] {
		PMB_OP_STORE,
		PMB_OP_RESTORE,
		PMB_OP_LOG_CLEAR,
		PMB_OP_LOG_STORE,
		PMB_OP_LOG_RESTORE,
		PMB_OP_NVM_ERASE,
		PMB_OP_NVM_DATA,
		PMB_OP_CFG_WRITE,
		PMB_OP_CLEAR_FAULTS
	} pmb_op_t;

	// bus-side sequencer states
	typedef enum logic [3:0] {
		PMB_ST_IDLE,
		PMB_ST_ADDR,
		PMB_ST_ADDR_ACK,
		PMB_ST_CMD,
		PMB_ST_CMD_ACK,
		PMB_ST_WDATA,
		PMB_ST_WDATA_ACK,
		PMB_ST_TX,
		PMB_ST_TX_ACK,
		PMB_ST_SKIP
	} pmb_state_t;

endpackage

/* File: core/pmb_strap_addr.sv */
// strap decode and base address register giving the slave address
`timescale 1ns/1ns
`include "pmb_defs.svh"
module pmb_strap_addr (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [1:0] addr_strap_lo,
	input wire logic [1:0] addr_strap_hi,
	input wire logic base_wr,
	input wire logic [6:0] base_wdata,
	output logic [6:0] dev_addr
);
	import pmb_pkg::*;

	logic [6:0] base;
	logic [3:0] offset;
	logic captured;

	// level code 3 cannot come from a three-level pin; read it as open
	function automatic logic [1:0] strap_level(input logic [1:0] code);
		strap_level = (code == 2'h3) ? 2'h1 : code;
	endfunction

	// any value is accepted
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			base <= `PMB_BASE_RST;
		end else if (base_wr) begin
			base <= base_wdata;
		end
	end

	// straps are caught once, on the first edge after reset release
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			captured <= 1'b0;
			offset <= 4'h0;
		end else if (!captured) begin
			captured <= 1'b1;
			offset <= 4'(`PMB_STRAP_MULT * strap_level(addr_strap_hi))
				+ {2'h0, strap_level(addr_strap_lo)};
		end
	end

	// base plus 0..8, wrapping in 7 bits
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			dev_addr <= `PMB_BASE_RST;
		end else begin
			dev_addr <= 7'(base + {3'h0, offset});
		end
	end
endmodule

/* File: core/pmb_addr_busy.sv */
// pmbus slave address decode, command acceptance and busy tracking
//
// Notes on behaviour
// - slave address is the stored base plus strap offset 0 to 8.
// - offset is three times upper strap level plus lower strap level.
// - base address register takes any value; resets to 0x5C.
// - global address 0x5B is always answered.
// - alert response address 0x0C is always answered on reads.
// - busy: ACK address, NACK command, drop it, set busy fault, pull alert.
// - common-status command is accepted even while busy, with no fault.
// - bit 6 of the common-status byte is high only when not busy.
// - stay busy after memory operations for their listed durations.
// - configuration style writes keep the device busy for 50 us.
// - clear-faults never makes busy; flags clear after 500 us.
// - status busy flag is set whenever a command is rejected.
// - optional error check byte and group commands pass as data bytes.
`timescale 1ns/1ns
`include "pmb_defs.svh"
module pmb_addr_busy #(
	parameter logic [7:0] STATUS_CMD = `PMB_STATUS_CMD_RST,
	parameter int STORE_CYC = `PMB_CYC_MS(`PMB_T_STORE_MS),
	parameter int RESTORE_CYC = `PMB_CYC_MS(`PMB_T_RESTORE_MS),
	parameter int LOG_CLEAR_CYC = `PMB_CYC_MS(`PMB_T_LOG_CLEAR_MS),
	parameter int LOG_STORE_CYC = `PMB_CYC_MS(`PMB_T_LOG_STORE_MS),
	parameter int LOG_RESTORE_CYC = `PMB_CYC_MS(`PMB_T_LOG_RESTORE_MS),
	parameter int NVM_CYC = `PMB_CYC_MS(`PMB_T_NVM_MS),
	parameter int CLR_CYC = `PMB_CYC_US(`PMB_T_CLR_US)
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic alert_n_in,
	output logic alert_n_out,
	output logic alert_n_oe,
	input wire logic [1:0] addr_strap_lo,
	input wire logic [1:0] addr_strap_hi,
	input wire logic base_wr,
	input wire logic [6:0] base_wdata,
	output logic [6:0] dev_addr,
	output logic cmd_valid,
	output logic [7:0] cmd_code,
	output logic wr_valid,
	output logic [7:0] wr_data,
	input wire logic [7:0] rd_data,
	output logic rd_take,
	output logic txn_end,
	input wire logic [7:0] status_in,
	input wire logic op_req,
	input wire pmb_pkg::pmb_op_t op_kind,
	output logic busy,
	output logic busy_fault,
	output logic faults_clr,
	output logic alert_seen
);
	import pmb_pkg::*;

	localparam int CFG_CYC = `PMB_CYC_US(`PMB_T_CFG_US);
	localparam int CNT_MAX = 2 ** `PMB_CNT_W;

	// counters are sized once; larger defaults would silently wrap
	if (STORE_CYC < 1 || STORE_CYC >= CNT_MAX || RESTORE_CYC < 1 ||
		RESTORE_CYC >= CNT_MAX || LOG_CLEAR_CYC < 1 || LOG_CLEAR_CYC >= CNT_MAX ||
		LOG_STORE_CYC < 1 || LOG_STORE_CYC >= CNT_MAX || LOG_RESTORE_CYC < 1 ||
		LOG_RESTORE_CYC >= CNT_MAX || NVM_CYC < 1 || NVM_CYC >= CNT_MAX ||
		CLR_CYC < 1 || CLR_CYC >= CNT_MAX) begin : g_bad_count
		$error("pmb_addr_busy: busy count out of range");
	end

	////////////////////////////////////////////////////////////////////////
	// bus conditions

	pmb_state_t state;
	logic scl_q;
	logic sda_q;
	logic [2:0] bit_cnt;
	logic [7:0] shreg;
	logic ack_half;
	logic is_read;
	logic ara_hit;
	logic cmd_ok;
	logic [7:0] cmd_reg;
	logic master_ack;
	logic [`PMB_CNT_W-1:0] busy_cnt;
	logic [`PMB_CNT_W-1:0] clr_cnt;

	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic [6:0] addr7;
	logic addr_hit;
	logic cmd_done;
	logic [7:0] cmd_now;
	logic cmd_accept;
	logic data_done;
	logic [7:0] status_byte;
	logic [7:0] tx_byte;
	logic tx_from_core;

	// pins are synchronous, so one stage of history is enough
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
		end
	end

	assign scl_rise = scl_in & ~scl_q;
	assign scl_fall = ~scl_in & scl_q;
	assign start_c = scl_in & scl_q & sda_q & ~sda_in;
	assign stop_c = scl_in & scl_q & ~sda_q & sda_in;

	// eighth address bit is the read flag, still on sda_in
	assign addr7 = shreg[6:0];
	assign addr_hit = (addr7 == dev_addr)
		| (addr7 == `PMB_GLOBAL_ADDR)
		| ((addr7 == `PMB_ARA_ADDR) & sda_in);

	assign cmd_done = (state == PMB_ST_CMD) & scl_rise & (bit_cnt == 3'h7);
	assign cmd_now = {shreg[6:0], sda_in};
	// only the status command slips past a busy device
	assign cmd_accept = ~busy | (cmd_now == STATUS_CMD);
	assign data_done = (state == PMB_ST_WDATA) & scl_rise & (bit_cnt == 3'h7);

	// ready bit replaces whatever the core puts there
	assign status_byte = {status_in[7], ~busy, status_in[5:0]};
	assign tx_from_core = ~ara_hit & ~(cmd_ok & (cmd_reg == STATUS_CMD));
	assign tx_byte = ara_hit ? {dev_addr, 1'b0} :
		(tx_from_core ? rd_data : status_byte);

	////////////////////////////////////////////////////////////////////////
	// slave sequencer

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state <= PMB_ST_IDLE;
			bit_cnt <= 3'h0;
			shreg <= 8'h00;
			ack_half <= 1'b0;
			is_read <= 1'b0;
			ara_hit <= 1'b0;
			cmd_ok <= 1'b0;
			cmd_reg <= 8'h00;
			master_ack <= 1'b0;
			sda_oe <= 1'b0;
		end else if (start_c) begin
			// repeated start keeps cmd_reg for the combined read
			state <= PMB_ST_ADDR;
			bit_cnt <= 3'h0;
			ack_half <= 1'b0;
			sda_oe <= 1'b0;
		end else if (stop_c) begin
			state <= PMB_ST_IDLE;
			sda_oe <= 1'b0;
		end else begin
			unique case (state)
				PMB_ST_IDLE, PMB_ST_SKIP: begin
				end
				PMB_ST_ADDR: begin
					if (scl_rise) begin
						shreg <= {shreg[6:0], sda_in};
						bit_cnt <= bit_cnt + 3'h1;
						if (bit_cnt == 3'h7) begin
							is_read <= sda_in;
							ara_hit <= (addr7 == `PMB_ARA_ADDR) & sda_in;
							if (!sda_in) begin
								cmd_ok <= 1'b0;
							end
							state <= addr_hit ? PMB_ST_ADDR_ACK : PMB_ST_SKIP;
						end
					end
				end
				PMB_ST_ADDR_ACK: begin
					// the address is acknowledged even while busy
					if (scl_fall) begin
						if (!ack_half) begin
							ack_half <= 1'b1;
							sda_oe <= 1'b1;
						end else begin
							ack_half <= 1'b0;
							bit_cnt <= 3'h0;
							if (is_read) begin
								shreg <= tx_byte;
								sda_oe <= ~tx_byte[7];
								state <= PMB_ST_TX;
							end else begin
								sda_oe <= 1'b0;
								state <= PMB_ST_CMD;
							end
						end
					end
				end
				PMB_ST_CMD: begin
					if (scl_rise) begin
						shreg <= cmd_now;
						bit_cnt <= bit_cnt + 3'h1;
						if (bit_cnt == 3'h7) begin
							cmd_reg <= cmd_now;
							cmd_ok <= cmd_accept;
							state <= PMB_ST_CMD_ACK;
						end
					end
				end
				PMB_ST_CMD_ACK: begin
					// a rejected command is left unacknowledged and dropped
					if (scl_fall) begin
						if (!ack_half) begin
							ack_half <= 1'b1;
							sda_oe <= cmd_ok;
						end else begin
							ack_half <= 1'b0;
							sda_oe <= 1'b0;
							bit_cnt <= 3'h0;
							state <= cmd_ok ? PMB_ST_WDATA : PMB_ST_SKIP;
						end
					end
				end
				PMB_ST_WDATA: begin
					if (scl_rise) begin
						shreg <= {shreg[6:0], sda_in};
						bit_cnt <= bit_cnt + 3'h1;
						if (bit_cnt == 3'h7) begin
							state <= PMB_ST_WDATA_ACK;
						end
					end
				end
				PMB_ST_WDATA_ACK: begin
					// data and check bytes alike are acknowledged
					if (scl_fall) begin
						if (!ack_half) begin
							ack_half <= 1'b1;
							sda_oe <= 1'b1;
						end else begin
							ack_half <= 1'b0;
							sda_oe <= 1'b0;
							bit_cnt <= 3'h0;
							state <= PMB_ST_WDATA;
						end
					end
				end
				PMB_ST_TX: begin
					if (scl_fall) begin
						bit_cnt <= bit_cnt + 3'h1;
						if (bit_cnt == 3'h7) begin
							sda_oe <= 1'b0;
							state <= PMB_ST_TX_ACK;
						end else begin
							shreg <= {shreg[6:0], 1'b0};
							sda_oe <= ~shreg[6];
						end
					end
				end
				PMB_ST_TX_ACK: begin
					if (scl_rise) begin
						master_ack <= ~sda_in;
					end else if (scl_fall) begin
						bit_cnt <= 3'h0;
						if (master_ack) begin
							shreg <= tx_byte;
							sda_oe <= ~tx_byte[7];
							state <= PMB_ST_TX;
						end else begin
							state <= PMB_ST_SKIP;
						end
					end
				end
			endcase
		end
	end

	// the pins are only ever pulled low
	assign sda_out = 1'b0;
	assign alert_n_out = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// strobes towards the command core

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cmd_valid <= 1'b0;
			cmd_code <= 8'h00;
			wr_valid <= 1'b0;
			wr_data <= 8'h00;
			rd_take <= 1'b0;
			txn_end <= 1'b0;
		end else begin
			cmd_valid <= cmd_done & cmd_accept;
			if (cmd_done) begin
				cmd_code <= cmd_now;
			end
			wr_valid <= data_done;
			if (data_done) begin
				wr_data <= {shreg[6:0], sda_in};
			end
			// a core byte is consumed when it is loaded for sending
			rd_take <= scl_fall & tx_from_core & (((state == PMB_ST_ADDR_ACK)
				& ack_half & is_read) | ((state == PMB_ST_TX_ACK) & master_ack));
			txn_end <= stop_c & (state != PMB_ST_IDLE) & (state != PMB_ST_SKIP);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// busy timing

	function automatic logic [`PMB_CNT_W-1:0] busy_len(input pmb_op_t kind);
		unique case (kind)
			PMB_OP_STORE: busy_len = `PMB_CNT_W'(STORE_CYC);
			PMB_OP_RESTORE: busy_len = `PMB_CNT_W'(RESTORE_CYC);
			PMB_OP_LOG_CLEAR: busy_len = `PMB_CNT_W'(LOG_CLEAR_CYC);
			PMB_OP_LOG_STORE: busy_len = `PMB_CNT_W'(LOG_STORE_CYC);
			PMB_OP_LOG_RESTORE: busy_len = `PMB_CNT_W'(LOG_RESTORE_CYC);
			PMB_OP_NVM_ERASE, PMB_OP_NVM_DATA: busy_len = `PMB_CNT_W'(NVM_CYC);
			PMB_OP_CFG_WRITE: busy_len = `PMB_CNT_W'(CFG_CYC);
			default: busy_len = `PMB_CNT_W'(0);
		endcase
	endfunction

	// the core raises op_req at the stop that ends the command
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			busy_cnt <= `PMB_CNT_W'(0);
			busy <= 1'b0;
		end else if (op_req && op_kind != PMB_OP_CLEAR_FAULTS) begin
			busy_cnt <= busy_len(op_kind);
			busy <= 1'b1;
		end else if (busy_cnt != `PMB_CNT_W'(0)) begin
			busy_cnt <= busy_cnt - `PMB_CNT_W'(1);
			busy <= busy_cnt != `PMB_CNT_W'(1);
		end
	end

	// clear-faults runs beside command traffic and never sets busy
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			clr_cnt <= `PMB_CNT_W'(0);
			faults_clr <= 1'b0;
		end else begin
			faults_clr <= clr_cnt == `PMB_CNT_W'(1);
			if (op_req && op_kind == PMB_OP_CLEAR_FAULTS) begin
				clr_cnt <= `PMB_CNT_W'(CLR_CYC);
			end else if (clr_cnt != `PMB_CNT_W'(0)) begin
				clr_cnt <= clr_cnt - `PMB_CNT_W'(1);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// busy fault and alert

	// a rejection in the clearing cycle wins, so the fault is not lost
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			busy_fault <= 1'b0;
			alert_n_oe <= 1'b0;
		end else if (cmd_done && !cmd_accept) begin
			busy_fault <= 1'b1;
			alert_n_oe <= 1'b1;
		end else if (faults_clr) begin
			busy_fault <= 1'b0;
			alert_n_oe <= 1'b0;
		end
	end

	// line level seen back, useful when several devices share the alert wire
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			alert_seen <= 1'b0;
		end else begin
			alert_seen <= ~alert_n_in;
		end
	end

	pmb_strap_addr u_strap (
		.core_clk(core_clk),
		.rst(rst),
		.addr_strap_lo(addr_strap_lo),
		.addr_strap_hi(addr_strap_hi),
		.base_wr(base_wr),
		.base_wdata(base_wdata),
		.dev_addr(dev_addr)
	);
endmodule

/* File: bench/pmb_addr_busy_asserts.sv */
// assertion checker for the address and busy block
`timescale 1ns/1ns
`include "pmb_defs.svh"
module pmb_addr_busy_asserts #(
	parameter logic [7:0] STATUS_CMD = `PMB_STATUS_CMD_RST
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic scl_in,
	input wire logic sda_oe,
	input wire logic alert_n_in,
	input wire logic alert_n_oe,
	input wire logic [1:0] addr_strap_lo,
	input wire logic [1:0] addr_strap_hi,
	input wire logic base_wr,
	input wire logic [6:0] base_wdata,
	input wire logic [6:0] dev_addr,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_code,
	input wire logic op_req,
	input wire pmb_pkg::pmb_op_t op_kind,
	input wire logic busy,
	input wire logic busy_fault,
	input wire logic faults_clr,
	input wire logic alert_seen
);
	import pmb_pkg::*;
	logic [6:0] offs;
	// code 3 on a strap reads as open
	function automatic logic [6:0] lvl(input logic [1:0] s);
		return (s == 2'h2) ? 7'h2 : {6'h0, s != 2'h0};
	endfunction
	assign offs = 7'h3 * lvl(addr_strap_hi) + lvl(addr_strap_lo);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	a_alert_fault: assert property (alert_n_oe == busy_fault)
		else $error("alert pin differs from busy fault");
	// base lands one edge after the strobe, the sum one edge later
	a_base_sum: assert property (base_wr |-> ##2 dev_addr == 7'($past(base_wdata, 2) + offs))
		else $error("slave address not base plus offset");
	a_op_busy: assert property (op_req && op_kind != PMB_OP_CLEAR_FAULTS |=> busy)
		else $error("operation did not make busy");
	a_clr_idle: assert property (op_req && op_kind == PMB_OP_CLEAR_FAULTS && !busy |=> !busy)
		else $error("clear faults made busy");
	a_fault_hold: assert property (busy_fault && !faults_clr |=> busy_fault)
		else $error("busy fault dropped without clear");
	a_fault_cause: assert property ($rose(busy_fault) |-> $past(busy))
		else $error("busy fault without busy");
	a_busy_cmd: assert property (cmd_valid && busy |-> cmd_code == STATUS_CMD)
		else $error("command accepted while busy");
	a_busy_bound: assert property ($rose(busy) |-> ##[1:1000] !busy)
		else $error("busy lasted too long");
	a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data line changed while clock high");
	a_alert_seen: assert property (alert_seen == $past(!alert_n_in))
		else $error("alert level not followed");
endmodule
bind pmb_addr_busy pmb_addr_busy_asserts #(.STATUS_CMD(STATUS_CMD)) chk_inst (.core_clk,
	.rst, .scl_in, .sda_oe, .alert_n_in, .alert_n_oe, .addr_strap_lo, .addr_strap_hi,
	.base_wr, .base_wdata, .dev_addr, .cmd_valid, .cmd_code, .op_req, .op_kind, .busy,
	.busy_fault, .faults_clr, .alert_seen);

/* File: bench/pmb_host_model.sv */
// bit-level bus master model
`timescale 1ns/1ns
module pmb_host_model #(
	parameter int Q = 3
) (
	input wire logic core_clk,
	input wire logic sda,
	output logic scl,
	output logic sda_drv
);
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	// also a repeated start, so a read can follow a command byte
	task automatic start();
		sda_drv <= 1'b1;
		wt(Q);
		scl <= 1'b1;
		wt(Q);
		sda_drv <= 1'b0;
		wt(Q);
		scl <= 1'b0;
		wt(Q);
	endtask
	task automatic stop();
		sda_drv <= 1'b0;
		wt(Q);
		scl <= 1'b1;
		wt(Q);
		sda_drv <= 1'b1;
		wt(Q);
	endtask
	// data set mid-low, sampled mid-high; a released line reads the pull-up
	task automatic bit_io(input logic b, output logic r);
		sda_drv <= b;
		wt(Q);
		scl <= 1'b1;
		wt(Q);
		r = sda;
		wt(Q);
		scl <= 1'b0;
		wt(Q);
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = !r;
	endtask
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(last, r);
	endtask
endmodule

/* File: bench/testbench.sv */
// self-checking bench for the address and busy block
`timescale 1ns/1ns
`include "pmb_defs.svh"
module testbench;
	import pmb_pkg::*;
	localparam int L = 20;
	localparam int LC = 900;
	localparam int CL = 300;
	localparam logic [7:0] SC = `PMB_STATUS_CMD_RST;
	logic core_clk, rst, scl_in, sda_drv, sda_out, sda_oe, alert_n_out, alert_n_oe;
	logic base_wr, cmd_valid, wr_valid, rd_take, txn_end, op_req, busy, busy_fault;
	logic faults_clr, alert_seen;
	logic [1:0] addr_strap_lo, addr_strap_hi;
	logic [6:0] base_wdata, dev_addr, a;
	logic [7:0] cmd_code, wr_data, rd_data, status_in;
	pmb_op_t op_kind;
	wire sda_in = sda_drv & ~sda_oe;
	wire alert_n_in = ~alert_n_oe;
	int failures, checks_done, n_cmd, n_wr, n_take, n_end;
	pmb_addr_busy #(.STORE_CYC(L), .RESTORE_CYC(L), .LOG_CLEAR_CYC(LC), .LOG_STORE_CYC(L),
		.LOG_RESTORE_CYC(L), .NVM_CYC(L), .CLR_CYC(CL)) pmb_addr_busy_inst (.core_clk,
		.rst, .scl_in, .sda_in, .sda_out, .sda_oe, .alert_n_in, .alert_n_out, .alert_n_oe,
		.addr_strap_lo, .addr_strap_hi, .base_wr, .base_wdata, .dev_addr, .cmd_valid,
		.cmd_code, .wr_valid, .wr_data, .rd_data, .rd_take, .txn_end, .status_in, .op_req,
		.op_kind, .busy, .busy_fault, .faults_clr, .alert_seen);
	pmb_host_model pmb_host_model_inst (.core_clk, .sda(sda_in), .scl(scl_in), .sda_drv);
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		if (cmd_valid === 1'b1) n_cmd++;
		if (wr_valid === 1'b1) n_wr++;
		if (rd_take === 1'b1) n_take++;
		if (txn_end === 1'b1) n_end++;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic do_reset();
		rst <= 1'b1;
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask
	function automatic int lv(input int s);
		return (s == 2) ? 2 : (s != 0);
	endfunction
	task automatic xfer_w(input logic [6:0] ad, input logic [7:0] c, output logic aa, ca);
		pmb_host_model_inst.start();
		pmb_host_model_inst.wbyte({ad, 1'b0}, aa);
		ca = 1'b0;
		if (aa) pmb_host_model_inst.wbyte(c, ca);
		pmb_host_model_inst.stop();
	endtask
	task automatic rd_status(output logic [7:0] d);
		logic x;
		pmb_host_model_inst.start();
		pmb_host_model_inst.wbyte({a, 1'b0}, x);
		pmb_host_model_inst.wbyte(SC, x);
		pmb_host_model_inst.start();
		pmb_host_model_inst.wbyte({a, 1'b1}, x);
		pmb_host_model_inst.rbyte(1'b1, d);
		pmb_host_model_inst.stop();
	endtask
	task automatic op(input pmb_op_t k);
		op_kind <= k;
		op_req <= 1'b1;
		@(posedge core_clk);
		op_req <= 1'b0;
	endtask
	task automatic t_straps();
		for (int h = 0; h < 4; h++) begin
			for (int l = 0; l < 4; l++) begin
				addr_strap_hi <= 2'(h);
				addr_strap_lo <= 2'(l);
				do_reset();
				chk({1'b0, dev_addr}, 8'(8'h5C + 3 * lv(h) + lv(l)));
			end
		end
		addr_strap_hi <= 2'h2;
		addr_strap_lo <= 2'h2;
		do_reset();
		chk({1'b0, dev_addr}, 8'h64);
	endtask
	task automatic t_addr();
		logic aa, ca;
		logic [7:0] d;
		base_wdata <= 7'h7E;
		base_wr <= 1'b1;
		@(posedge core_clk);
		base_wr <= 1'b0;
		// base register first, then the registered sum
		repeat (2) @(posedge core_clk);
		// 0x7E plus 8 wraps past the seven-bit range
		chk({1'b0, dev_addr}, 8'h06);
		a = 7'h06;
		xfer_w(a, 8'h21, aa, ca);
		chk({aa, ca}, 8'h03);
		xfer_w(7'h64, 8'h21, aa, ca);
		chk({aa, ca}, 8'h00);
		xfer_w(7'h5B, 8'h01, aa, ca);
		chk({aa, ca}, 8'h03);
		pmb_host_model_inst.start();
		pmb_host_model_inst.wbyte({7'h0C, 1'b1}, aa);
		pmb_host_model_inst.rbyte(1'b1, d);
		pmb_host_model_inst.stop();
		chk({7'h00, aa}, 8'h01);
		chk(d, {7'h06, 1'b0});
	endtask
	task automatic t_data();
		logic x;
		logic [7:0] d;
		int w0, t0, e0;
		w0 = n_wr;
		t0 = n_take;
		e0 = n_end;
		pmb_host_model_inst.start();
		pmb_host_model_inst.wbyte({a, 1'b0}, x);
		pmb_host_model_inst.wbyte(8'h21, x);
		pmb_host_model_inst.wbyte(8'hA5, x);
		pmb_host_model_inst.stop();
		@(posedge core_clk);
		chk({x, 7'(n_wr - w0)}, 8'h81);
		chk(wr_data, 8'hA5);
		chk(cmd_code, 8'h21);
		pmb_host_model_inst.start();
		pmb_host_model_inst.wbyte({a, 1'b0}, x);
		pmb_host_model_inst.wbyte(8'h21, x);
		pmb_host_model_inst.start();
		pmb_host_model_inst.wbyte({a, 1'b1}, x);
		pmb_host_model_inst.rbyte(1'b1, d);
		pmb_host_model_inst.stop();
		@(posedge core_clk);
		chk(d, 8'h3C);
		// a read ended by the host's nack is not counted as a finished write
		chk({2'(n_take - t0), 2'(n_end - e0), sda_out, alert_n_out}, 8'h14);
	endtask
	task automatic t_busy_len();
		int n, len;
		for (int i = 0; i < 8; i++) begin
			len = (i == 7) ? 500 : (i == 2) ? LC : L;
			op(pmb_op_t'(i));
			n = 0;
			@(posedge core_clk);
			while (busy === 1'b1 && n < 1200) begin
				n++;
				@(posedge core_clk);
			end
			chk(8'(n == len || n == len + 1), 8'h01);
		end
	endtask
	task automatic t_busy_bus();
		logic aa, ca;
		logic [7:0] d;
		int c0, k;
		op(PMB_OP_LOG_CLEAR);
		c0 = n_cmd;
		rd_status(d);
		chk(d, 8'hBF);
		chk({busy_fault, alert_seen, 6'(n_cmd - c0)}, 8'h01);
		xfer_w(a, 8'h21, aa, ca);
		chk({aa, ca}, 8'h02);
		chk({busy_fault, alert_seen, 6'(n_cmd - c0)}, 8'hC1);
		k = 0;
		d = 8'h00;
		while (d[6] !== 1'b1 && k < 10) begin
			rd_status(d);
			k++;
		end
		chk(d, 8'hFF);
	endtask
	task automatic t_clear();
		logic aa, ca;
		int n;
		op(PMB_OP_CLEAR_FAULTS);
		xfer_w(a, 8'h01, aa, ca);
		// flags may lag the clear while commands are already accepted
		chk({aa, ca, busy, busy_fault}, 8'h0D);
		n = 0;
		while (busy_fault !== 1'b0 && n < CL) begin
			n++;
			@(posedge core_clk);
		end
		@(posedge core_clk);
		chk({busy_fault, alert_seen}, 8'h00);
	endtask
	initial begin
		failures = 0;
		checks_done = 0;
		n_cmd = 0;
		n_wr = 0;
		n_take = 0;
		n_end = 0;
		rst = 1'b1;
		addr_strap_lo = 2'h0;
		addr_strap_hi = 2'h0;
		base_wr = 1'b0;
		base_wdata = 7'h00;
		rd_data = 8'h3C;
		status_in = 8'hFF;
		op_req = 1'b0;
		op_kind = PMB_OP_STORE;
		a = 7'h06;
		t_straps();
		t_addr();
		t_data();
		t_busy_len();
		t_busy_bus();
		t_clear();
		wrap_up();
	end
	initial begin
		repeat (40000) @(posedge core_clk);
		failures++;
		wrap_up();
	end
endmodule
